// ==== rtl/smhj_pkg.sv ====
/*
  Constants shared by the step motion home and jog sequencer.
  Assumes a single 25 MHz system clock; speeds are whole steps per second.
*/
package smhj_pkg;

  // Clock
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
  localparam logic [32:0] CLK_HZ_W      = 33'(CLK_HZ);

  // Largest distance an absolute move may span, in microsteps
  localparam logic signed [32:0] POS_SPAN_MAX = 33'sh0_7fffffff;
  localparam logic signed [32:0] POS_SPAN_MIN = -33'sh0_7fffffff;

  // Error codes
  localparam logic [7:0] ERR_NONE  = 8'h00;
  localparam logic [7:0] ERR_RANGE = 8'h15;

  // Reset values
  localparam logic [31:0] START_SPEED_RST = 32'h00000000;
  localparam logic [31:0] POS_RST         = 32'h00000000;

  // Home trigger selection codes
  localparam logic [1:0] TRIG_FIRST  = 2'h0;
  localparam logic [1:0] TRIG_SECOND = 2'h1;
  localparam logic [1:0] TRIG_MARKER = 2'h2;

  // Bit positions in the synchronised pin vector
  localparam int PIN_FIRST  = 0;
  localparam int PIN_SECOND = 1;
  localparam int PIN_MARKER = 2;
  localparam int PIN_ESTEP  = 3;
  localparam int PIN_EDIR   = 4;
  localparam int PIN_COUNT  = 5;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MOVE,
    ST_JOG,
    ST_HOME_RUN,
    ST_WIND_DOWN
  } smhj_state_e;

endpackage

// ==== rtl/smhj_sequencer.sv ====
/*
  Motion sequencer: absolute moves, jog, start speed and homing cycle.
  Assumes command strobes come from logic on sys_clk; trigger and encoder
  pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
// What this block does
// [R1] Absolute move beyond span: error 21, no motion
// [R2] Jog direction positive unless value negative
// [R3] Jog uses last programmed running speed
// [R4] Jog continues until stop command
// [R5] Start speed register, readable, resets zero
// [R6] Home direction from sign, running speed
// [R7] Home trigger selectable: input one, two, marker
// [R8] Trigger already fired: zero positions, stay
// [R9] Home accelerates to speed until trigger
// [R10] On trigger decelerate at ramp down rate
// [R11] Positions count travel since trigger point
// [R12] Busy from motion start until rest
module smhj_sequencer
  import smhj_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        absMoveStart,
  input  wire logic [31:0] absMoveTarget,
  input  wire logic        jogStart,
  input  wire logic [31:0] jogValue,
  input  wire logic        homeStart,
  input  wire logic [31:0] homeValue,
  input  wire logic        stopCmd,
  input  wire logic [31:0] runSpeed,
  input  wire logic [31:0] accelRate,
  input  wire logic [31:0] rampDownRate,
  input  wire logic        startSpeedWrite,
  input  wire logic [31:0] startSpeedIn,
  input  wire logic [1:0]  triggerSelect,
  input  wire logic        firstTriggerInput,
  input  wire logic        secondTriggerInput,
  input  wire logic        encoderMarker,
  input  wire logic        encoderStep,
  input  wire logic        encoderDir,
  output logic             stepOut,
  output logic             dirOut,
  output logic             busy,
  output logic [31:0]      startSpeed,
  output logic [31:0]      absolutePosition,
  output logic [31:0]      encoderPosition,
  output logic             errorValid,
  output logic [7:0]       errorCode
);

  // Selected home trigger level; used before and during the cycle
  function automatic logic trig_hit(input logic [1:0] sel,
                                    input logic [PIN_COUNT-1:0] pins);
    case (sel)
      TRIG_FIRST:  trig_hit = pins[PIN_FIRST];
      TRIG_SECOND: trig_hit = pins[PIN_SECOND];
      TRIG_MARKER: trig_hit = pins[PIN_MARKER];
      default:     trig_hit = 1'b0;
    endcase
  endfunction

  logic [PIN_COUNT-1:0] pinRaw;
  logic [PIN_COUNT-1:0] meta_q;
  logic [PIN_COUNT-1:0] pins_q;
  logic                 encStepPrev_q;

  smhj_state_e state_q, state_d;
  logic        dir_q, dir_d;
  logic [31:0] target_q, target_d;
  logic [31:0] absolute_position_q, absolute_position_d;
  logic [31:0] encoder_position_q, encoder_position_d;
  logic [31:0] startSpeed_q, startSpeed_d;
  logic [7:0]  errCode_q, errCode_d;
  logic        errValid_q, errValid_d;

  logic        genStart;
  logic        genRun;
  logic        genHalt;
  logic        genAllow;
  logic        genStep;
  logic        genMoving;
  logic [31:0] genSpeed;
  logic        zeroPos;
  logic [31:0] remaining;
  logic        brake;

  assign pinRaw = {encoderDir, encoderStep, encoderMarker, secondTriggerInput, firstTriggerInput};

  // Two-stage synchronisers; nothing looks at the first stage
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          meta_q[gi] <= 1'b0;
          pins_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= pinRaw[gi];
          pins_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // Distance left to the target and the braking test:
  // brake once 2*ramp_down_rate*remaining no longer exceeds v^2 - vs^2
  always_comb begin
    logic [64:0] stopRoom;
    logic [64:0] energy;
    logic [63:0] vSq;
    logic [63:0] vsSq;
    remaining = dir_q ? (target_q - absolute_position_q) : (absolute_position_q - target_q);
    stopRoom  = {1'b0, {32'h00000000, rampDownRate} * {32'h00000000, remaining}} << 1;
    vSq       = {32'h00000000, genSpeed} * {32'h00000000, genSpeed};
    vsSq      = {32'h00000000, startSpeed_q} * {32'h00000000, startSpeed_q};
    energy    = (vSq > vsSq) ? {1'b0, vSq - vsSq} : 65'h0;
    // A zero rate stops dead at the target, and braking only happens above
    // start speed, so a move can never stall short of its target
    brake     = (rampDownRate != 32'h00000000) && (stopRoom <= energy);
  end

  // Sequencer state; new commands are only taken while idle
  always_comb begin
    logic signed [32:0] span;
    span       = $signed({absMoveTarget[31], absMoveTarget}) - $signed({absolute_position_q[31], absolute_position_q});
    state_d    = state_q;
    dir_d      = dir_q;
    target_d   = target_q;
    errCode_d  = errCode_q;
    errValid_d = 1'b0;
    genStart   = 1'b0;
    genRun     = 1'b0;
    genHalt    = 1'b0;
    zeroPos    = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (genMoving) begin
          state_d = ST_IDLE;
        end else if (absMoveStart) begin
          if (span > POS_SPAN_MAX || span < POS_SPAN_MIN) begin
            errCode_d  = ERR_RANGE; // [R1]
            errValid_d = 1'b1; // [R1]
          end else if (span != 33'sh0) begin
            dir_d    = ~span[32];
            target_d = absMoveTarget;
            genStart = 1'b1;
            state_d  = ST_MOVE;
          end
        end else if (jogStart) begin
          dir_d    = ~jogValue[31]; // [R2]
          genStart = 1'b1;
          state_d  = ST_JOG;
        end else if (homeStart) begin
          if (trig_hit(triggerSelect, pins_q)) begin
            zeroPos = 1'b1; // [R8]
          end else begin
            dir_d    = ~homeValue[31]; // [R6]
            genStart = 1'b1;
            state_d  = ST_HOME_RUN;
          end
        end
      end
      ST_MOVE: begin
        genRun = ~brake;
        if (remaining == 32'h00000000) begin
          genHalt = 1'b1;
          state_d = ST_IDLE;
        end else if (stopCmd) begin
          state_d = ST_WIND_DOWN;
        end
      end
      ST_JOG: begin
        genRun = 1'b1;
        if (stopCmd) begin
          state_d = ST_WIND_DOWN; // [R4]
        end
      end
      ST_HOME_RUN: begin
        genRun = 1'b1; // [R9]
        if (trig_hit(triggerSelect, pins_q)) begin // [R7]
          zeroPos = 1'b1; // [R11]
          state_d = ST_WIND_DOWN; // [R10]
        end else if (stopCmd) begin
          state_d = ST_WIND_DOWN;
        end
      end
      ST_WIND_DOWN: begin
        if (!genMoving) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // No extra step once an absolute move sits on its target
  assign genAllow = ~((state_q == ST_MOVE) && (remaining == 32'h00000000));

  // Position counters; zeroing at the trigger wins over a same-cycle count,
  // after which both simply count the travel past the trigger point
  always_comb begin
    logic encEdge;
    encEdge      = pins_q[PIN_ESTEP] & ~encStepPrev_q;
    absolute_position_d     = absolute_position_q;
    encoder_position_d     = encoder_position_q;
    startSpeed_d = startSpeed_q;
    if (zeroPos) begin
      absolute_position_d = POS_RST; // [R11]
      encoder_position_d = POS_RST; // [R8]
    end else begin
      if (genStep) begin
        absolute_position_d = dir_q ? absolute_position_q + 32'h00000001 : absolute_position_q - 32'h00000001;
      end
      if (encEdge) begin
        encoder_position_d = pins_q[PIN_EDIR] ? encoder_position_q + 32'h00000001 : encoder_position_q - 32'h00000001;
      end
    end
    if (startSpeedWrite) begin
      startSpeed_d = startSpeedIn; // [R5]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q       <= ST_IDLE;
      dir_q         <= 1'b1;
      target_q      <= POS_RST;
      absolute_position_q      <= POS_RST;
      encoder_position_q      <= POS_RST;
      startSpeed_q  <= START_SPEED_RST; // [R5]
      errCode_q     <= ERR_NONE;
      errValid_q    <= 1'b0;
      encStepPrev_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      dir_q         <= dir_d;
      target_q      <= target_d;
      absolute_position_q      <= absolute_position_d;
      encoder_position_q      <= encoder_position_d;
      startSpeed_q  <= startSpeed_d;
      errCode_q     <= errCode_d;
      errValid_q    <= errValid_d;
      encStepPrev_q <= pins_q[PIN_ESTEP];
    end
  end

  // Jog and home always run at the live running speed input
  smhj_step_gen u_step_gen (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .startPulse  (genStart),
    .runReq      (genRun),
    .halt        (genHalt),
    .stepAllow   (genAllow),
    .targetSpeed (runSpeed), // [R3]
    .startSpeed  (startSpeed_q),
    .accelRate   (accelRate),
    .decelRate   (rampDownRate),
    .stepPulse   (genStep),
    .moving      (genMoving),
    .curSpeed    (genSpeed)
  );

  // Outputs
  assign stepOut          = genStep;
  assign dirOut           = dir_q;
  assign busy             = (state_q != ST_IDLE) | genMoving; // [R12]
  assign startSpeed       = startSpeed_q;
  assign absolutePosition = absolute_position_q;
  assign encoderPosition  = encoder_position_q;
  assign errorValid       = errValid_q;
  assign errorCode        = errCode_q;

endmodule

// ==== rtl/smhj_step_gen.sv ====
/*
  Velocity ramp and step pulse generator for the sequencer.
  Assumes speeds stay below half the clock rate so at most one step per cycle.
*/
`timescale 1ns/1ns
module smhj_step_gen
  import smhj_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        startPulse,
  input  wire logic        runReq,
  input  wire logic        halt,
  input  wire logic        stepAllow,
  input  wire logic [31:0] targetSpeed,
  input  wire logic [31:0] startSpeed,
  input  wire logic [31:0] accelRate,
  input  wire logic [31:0] decelRate,
  output logic             stepPulse,
  output logic             moving,
  output logic [31:0]      curSpeed
);

  logic [31:0] vel_q, vel_d;
  logic [31:0] rampAcc_q, rampAcc_d;
  logic [31:0] phase_q, phase_d;
  logic        moving_q, moving_d;
  logic        step_q, step_d;

  // Rate accumulators: one speed unit per CLK_HZ of accumulated rate; a fast
  // ramp moves the speed several units a cycle so the programmed rate holds
  always_comb begin
    logic [31:0] rate;
    logic [32:0] rampSum;
    logic [32:0] rampSteps;
    logic [32:0] rampLeft;
    logic [32:0] velUp;
    logic [32:0] aboveStart;
    logic [32:0] phaseSum;
    logic [32:0] phaseDiff;
    rate       = runReq ? accelRate : decelRate;
    rampSum    = {1'b0, rampAcc_q} + {1'b0, rate};
    rampSteps  = rampSum / CLK_HZ_W;
    rampLeft   = rampSum % CLK_HZ_W;
    velUp      = {1'b0, vel_q} + rampSteps;
    aboveStart = {1'b0, vel_q} - {1'b0, startSpeed}; // Only read above start speed
    phaseSum   = {1'b0, phase_q} + {1'b0, vel_q};
    phaseDiff  = phaseSum - CLK_HZ_W;
    vel_d     = vel_q;
    rampAcc_d = rampAcc_q;
    phase_d   = phase_q;
    moving_d  = moving_q;
    step_d    = 1'b0;
    if (halt) begin
      vel_d     = 32'h00000000;
      rampAcc_d = 32'h00000000;
      phase_d   = 32'h00000000;
      moving_d  = 1'b0;
    end else if (startPulse) begin
      vel_d     = startSpeed;
      rampAcc_d = 32'h00000000;
      phase_d   = 32'h00000000;
      moving_d  = 1'b1;
    end else if (moving_q) begin
      rampAcc_d = rampLeft[31:0];
      if (runReq) begin
        // A zero rate means an instant change of speed
        if (rate == 32'h00000000 || velUp >= {1'b0, targetSpeed}) begin
          vel_d = targetSpeed;
        end else begin
          vel_d = velUp[31:0]; // [R9]
        end
      end else if (vel_q <= startSpeed) begin
        vel_d    = 32'h00000000;
        moving_d = 1'b0;
      end else if (rate == 32'h00000000 || rampSteps >= aboveStart) begin
        vel_d = startSpeed;
      end else begin
        vel_d = vel_q - rampSteps[31:0]; // [R10]
      end
      if (phaseSum >= CLK_HZ_W) begin
        phase_d = phaseDiff[31:0];
        step_d  = stepAllow;
      end else begin
        phase_d = phaseSum[31:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vel_q     <= 32'h00000000;
      rampAcc_q <= 32'h00000000;
      phase_q   <= 32'h00000000;
      moving_q  <= 1'b0;
      step_q    <= 1'b0;
    end else begin
      vel_q     <= vel_d;
      rampAcc_q <= rampAcc_d;
      phase_q   <= phase_d;
      moving_q  <= moving_d;
      step_q    <= step_d;
    end
  end

  assign stepPulse = step_q;
  assign moving    = moving_q;
  assign curSpeed  = vel_q;

endmodule

// ==== testbench/smhj_drive_model.sv ====
/*
  Drive and sensor model: encoder follows the steps, trigger level from the bench.
  Assumes steps at least eight cycles apart.
*/
`timescale 1ns/1ns
module smhj_drive_model (
  input  wire logic       sys_clk,
  input  wire logic       stepOut,
  input  wire logic       dirOut,
  input  wire logic [1:0] trigSel,
  input  wire logic       trigLevel,
  output logic            firstTriggerInput,
  output logic            secondTriggerInput,
  output logic            encoderMarker,
  output logic            encoderStep,
  output logic            encoderDir
);
  logic [1:0] encHold = 2'h0;
  logic       encDir = 1'b1;
  // Stretch each step to three cycles so the synchroniser cannot miss it
  always @(posedge sys_clk) begin
    encDir <= dirOut;
    if (stepOut) encHold <= 2'h3;
    else if (encHold != 2'h0) encHold <= encHold - 2'h1;
  end
  assign encoderStep = (encHold != 2'h0);
  assign encoderDir = encDir;
  // Unselected lines sit active, so a wrong selection homes at once
  assign firstTriggerInput = (trigSel == 2'h0) ? trigLevel : 1'b1;
  assign secondTriggerInput = (trigSel == 2'h1) ? trigLevel : 1'b1;
  assign encoderMarker = (trigSel == 2'h2) ? trigLevel : 1'b1;
endmodule

// ==== testbench/smhj_seq_monitor.sv ====
/*
  Port checker for the sequencer top.
  Assumes one clock and a synchronous active low reset.
*/
`timescale 1ns/1ns
module smhj_seq_monitor
  import smhj_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        absMoveStart,
  input wire logic [31:0] absMoveTarget,
  input wire logic        jogStart,
  input wire logic [31:0] jogValue,
  input wire logic        homeStart,
  input wire logic [31:0] homeValue,
  input wire logic        stopCmd,
  input wire logic        startSpeedWrite,
  input wire logic [31:0] startSpeedIn,
  input wire logic        stepOut,
  input wire logic        dirOut,
  input wire logic        busy,
  input wire logic [31:0] startSpeed,
  input wire logic [31:0] absolutePosition,
  input wire logic        errorValid,
  input wire logic [7:0]  errorCode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic signed [32:0] moveSpan;
  logic               farMove;
  logic               jogOn_q, jogOn_d, stopSeen_q, stopSeen_d;
  // Distance of a requested move, one bit wider so it cannot wrap
  assign moveSpan = $signed({absMoveTarget[31], absMoveTarget})
                  - $signed({absolutePosition[31], absolutePosition});
  assign farMove = (moveSpan > POS_SPAN_MAX) || (moveSpan < POS_SPAN_MIN);
  // Tracks a jog that has not yet been told to stop
  always_comb begin
    jogOn_d = (jogStart && !busy && !absMoveStart) || (busy && jogOn_q);
    stopSeen_d = busy && (stopSeen_q || stopCmd);
  end
  always_ff @(posedge sys_clk) begin
    jogOn_q <= rst_n && jogOn_d;
    stopSeen_q <= rst_n && stopSeen_d;
  end
  property p_range;
    absMoveStart && !busy && farMove |=> errorValid && errorCode == ERR_RANGE && !busy;
  endproperty
  a_range: assert property (p_range) else $error("range error not flagged");
  property p_still;
    absMoveStart && !busy && farMove |=> (!busy && !stepOut) [*4];
  endproperty
  a_still: assert property (p_still) else $error("motion after range error");
  property p_code;
    $changed(errorCode) |-> errorValid && errorCode == ERR_RANGE;
  endproperty
  a_code: assert property (p_code) else $error("error code changed alone");
  property p_jogDir;
    jogStart && !busy && !absMoveStart |=> busy && dirOut == !$past(jogValue[31]);
  endproperty
  a_jogDir: assert property (p_jogDir) else $error("jog direction wrong");
  property p_jogHold;
    jogOn_q && busy && !stopSeen_q && !stopCmd |=> busy;
  endproperty
  a_jogHold: assert property (p_jogHold) else $error("jog ended by itself");
  property p_speedLoad;
    startSpeedWrite |=> startSpeed == $past(startSpeedIn);
  endproperty
  a_speedLoad: assert property (p_speedLoad) else $error("start speed not loaded");
  property p_speedHold;
    !startSpeedWrite |=> $stable(startSpeed);
  endproperty
  a_speedHold: assert property (p_speedHold) else $error("start speed drifted");
  property p_homeDir;
    (homeStart && !busy && !absMoveStart && !jogStart) ##1 busy
      |-> dirOut == !$past(homeValue[31]);
  endproperty
  a_homeDir: assert property (p_homeDir) else $error("home direction wrong");
  property p_stepBusy;
    stepOut |-> busy;
  endproperty
  a_stepBusy: assert property (p_stepBusy) else $error("step while idle");
  property p_moveBusy;
    absMoveStart && !busy && !farMove && absMoveTarget != absolutePosition |=> busy;
  endproperty
  a_moveBusy: assert property (p_moveBusy) else $error("move did not go busy");
  c_range: cover property (absMoveStart && !busy && farMove);
  c_jogStop: cover property (jogOn_q && stopCmd);
  c_home: cover property (homeStart && !busy);
endmodule

bind smhj_sequencer smhj_seq_monitor i_smhj_seq_monitor (
  .sys_clk(sys_clk), .rst_n(rst_n), .absMoveStart(absMoveStart),
  .absMoveTarget(absMoveTarget), .jogStart(jogStart), .jogValue(jogValue),
  .homeStart(homeStart), .homeValue(homeValue), .stopCmd(stopCmd),
  .startSpeedWrite(startSpeedWrite), .startSpeedIn(startSpeedIn), .stepOut(stepOut),
  .dirOut(dirOut), .busy(busy), .startSpeed(startSpeed),
  .absolutePosition(absolutePosition), .errorValid(errorValid), .errorCode(errorCode));

// ==== testbench/smhj_sequencer_bench.sv ====
/*
  Self-checking bench for the sequencer, with a step counting motion model.
  Assumes the drive model on the far side and the bound port checker.
*/
`timescale 1ns/1ns
module smhj_sequencer_bench;
  import smhj_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, absMoveStart = 1'b0, jogStart = 1'b0;
  logic homeStart = 1'b0, stopCmd = 1'b0, startSpeedWrite = 1'b0, trigLevel = 1'b0;
  logic [31:0] absMoveTarget = 32'h0, jogValue = 32'h0, homeValue = 32'h0;
  logic [31:0] runSpeed = 32'h000f4240, accelRate = 32'h0, rampDownRate = 32'h0;
  logic [31:0] startSpeedIn = 32'h0;
  logic [1:0]  triggerSelect = 2'h3;
  logic        firstTriggerInput, secondTriggerInput, encoderMarker, encoderStep, encoderDir;
  logic        stepOut, dirOut, busy, errorValid, clrCnt = 1'b0;
  logic [31:0] startSpeed, absolutePosition, encoderPosition;
  logic [7:0]  errorCode;
  int          error_cnt = 0, checked = 0, cycles = 0, stepCnt = 0, base, expS;
  smhj_sequencer i_smhj_sequencer (.sys_clk(sys_clk), .rst_n(rst_n),
    .absMoveStart(absMoveStart), .absMoveTarget(absMoveTarget), .jogStart(jogStart),
    .jogValue(jogValue), .homeStart(homeStart), .homeValue(homeValue), .stopCmd(stopCmd),
    .runSpeed(runSpeed), .accelRate(accelRate), .rampDownRate(rampDownRate),
    .startSpeedWrite(startSpeedWrite), .startSpeedIn(startSpeedIn),
    .triggerSelect(triggerSelect), .firstTriggerInput(firstTriggerInput),
    .secondTriggerInput(secondTriggerInput), .encoderMarker(encoderMarker),
    .encoderStep(encoderStep), .encoderDir(encoderDir), .stepOut(stepOut), .dirOut(dirOut),
    .busy(busy), .startSpeed(startSpeed), .absolutePosition(absolutePosition),
    .encoderPosition(encoderPosition), .errorValid(errorValid), .errorCode(errorCode));
  smhj_drive_model i_smhj_drive_model (.sys_clk(sys_clk), .stepOut(stepOut),
    .dirOut(dirOut), .trigSel(triggerSelect), .trigLevel(trigLevel),
    .firstTriggerInput(firstTriggerInput), .secondTriggerInput(secondTriggerInput),
    .encoderMarker(encoderMarker), .encoderStep(encoderStep), .encoderDir(encoderDir));
  // 25 MHz clock
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // Motion model: signed step count, cleared at the trigger point
  always @(posedge sys_clk) begin
    if (clrCnt) stepCnt <= 0;
    else if (stepOut === 1'b1) stepCnt <= stepCnt + (dirOut ? 1 : -1);
  end
  // Hang guard sized well above the longest homing runs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      error_cnt++;
      stop_test();
    end
  end
  function automatic int iabs(int v);
    return (v < 0) ? -v : v;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobe high for one clock edge, driven on falling edges
  task automatic strobe(ref logic s);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask
  task automatic waitIdle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    check(32'(n < lim), 32'h1);
  endtask
  task stop_test();
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hfb495b87));
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    check(startSpeed, START_SPEED_RST);
    check(busy, 32'h0);
    expS = $urandom_range(1, 50000);
    startSpeedIn = 32'(expS);
    strobe(startSpeedWrite);
    check(startSpeed, 32'(expS));
    absMoveTarget = 32'hfffffff6;
    strobe(absMoveStart);
    check(busy, 32'h1);
    waitIdle(2000);
    check(absolutePosition, 32'(stepCnt));
    check(32'(stepCnt), 32'hfffffff6);
    // Span from -10 to the top of the range is ten past the limit
    absMoveTarget = 32'h7fffffff;
    strobe(absMoveStart);
    check(errorValid, 32'h1);
    check(errorCode, ERR_RANGE);
    repeat (20) @(negedge sys_clk);
    check(absolutePosition, 32'hfffffff6);
    // Zero then negative jog; speed doubled mid run must take effect
    for (int k = 0; k < 2; k++) begin
      jogValue = k ? ($urandom() | 32'h80000000) : 32'h0;
      strobe(jogStart);
      check(dirOut, 32'(k == 0));
      for (int s = 1; s < 3; s++) begin
        runSpeed = 32'h000f4240 * s;
        base = stepCnt;
        repeat (1000) @(negedge sys_clk);
        check(32'(iabs(stepCnt - base - (k ? -40 * s : 40 * s)) <= 1), 32'h1);
      end
      check(busy, 32'h1);
      strobe(stopCmd);
      waitIdle(100);
      check(absolutePosition, 32'(stepCnt));
    end
    runSpeed = 32'h000f4240;
    accelRate = 32'hfa000000;
    rampDownRate = 32'hfa000000;
    for (int t = 0; t < 3; t++) begin
      triggerSelect = 2'(t);
      trigLevel = 1'b1;
      homeValue = (t == 1) ? $urandom_range(0, 999) : ($urandom() | 32'h80000000);
      repeat (4) @(negedge sys_clk);
      strobe(homeStart);
      check(busy, 32'h0);
      @(negedge sys_clk);
      check(absolutePosition, POS_RST);
      check(encoderPosition, POS_RST);
      trigLevel = 1'b0;
      repeat (4) @(negedge sys_clk);
      strobe(homeStart);
      check(dirOut, 32'(t == 1));
      repeat (7000) @(negedge sys_clk);
      base = stepCnt;
      repeat (250) @(negedge sys_clk);
      check(32'(iabs(iabs(stepCnt - base) - 10) <= 1), 32'h1);
      for (int n = 0; n < 100 && stepOut !== 1'b1; n++) @(negedge sys_clk);
      repeat (5) @(negedge sys_clk);
      trigLevel = 1'b1;
      clrCnt = 1'b1;
      @(negedge sys_clk);
      clrCnt = 1'b0;
      waitIdle(20000);
      repeat (10) @(negedge sys_clk);
      check(32'(iabs(stepCnt) >= 110 && iabs(stepCnt) <= 130), 32'h1);
      check(absolutePosition, 32'(stepCnt));
      check(encoderPosition, 32'(stepCnt));
    end
    stop_test();
  end
endmodule
